// ==== hdl/ufir_defines.svh ====
// register offsets, field positions, reset values of the usb flag routing block
//
// Operation
// - any bank1 source sets its flag; flag with its enable requests an interrupt
// - writing 0 clears a flag bit; bits written 1 stay unchanged
// - reserved bits 7..4 of flags1 and 7..3 of select1 read 0, write 0
// - flags1 bit 3 is a live, uncleared copy of the vbus pin
// - in token to endpoint 3 with no valid data sets flag bit 2
// - endpoint 3 in tokens get nack until data is written and enabled
// - ack after endpoint 3 transmit sets flag bit 1
// - vbus attach or detach sets flag bit 0
// - bank0 select bit 0 routes to line zero, 1 routes to line one
// - select0 has eight read/write bits, all reset to 0
// - bank1 select bit 1 routes to line one, 0 to line zero
// - select1 bits 2..0 reset to 1
// - when both lines request, line zero has priority
// - a flag requests only while its enable bit is 1
// - bank0 full and empty status bits cannot be cleared by software
`ifndef UFIR_DEFINES_SVH
`define UFIR_DEFINES_SVH

// ----------------------------------------
// byte offsets on the register bus
// ----------------------------------------
`define UFIR_OFF_FLAGS1 8'h00
`define UFIR_OFF_SEL0 8'h04
`define UFIR_OFF_SEL1 8'h08
`define UFIR_OFF_FLAGS0 8'h0C
`define UFIR_OFF_EVT_STAT 8'h10
`define UFIR_OFF_EVT_CLR 8'h14
`define UFIR_OFF_EVT_EN 8'h18

// ----------------------------------------
// field positions
// ----------------------------------------
`define UFIR_F1_CONN 0
`define UFIR_F1_EP3_DONE 1
`define UFIR_F1_EP3_REQ 2
`define UFIR_F1_VBUS_MON 3
`define UFIR_F0_EP1_FULL 6
`define UFIR_F0_EP2_EMPTY 4
`define UFIR_EVT_ATTACH 0
`define UFIR_EVT_DETACH 1
`define UFIR_EVT_NACK 2

// ----------------------------------------
// reset values and masks
// ----------------------------------------
`define UFIR_RST_FLAGS1 3'h0
`define UFIR_RST_SEL0 8'h00
`define UFIR_RST_SEL1 3'h7
`define UFIR_RST_EVT 3'h0
`define UFIR_F0_STATUS_MASK 8'h50

`endif

// ==== hdl/ufir_pkg.sv ====
// types shared by the usb flag routing block
package ufir_pkg;
    typedef logic [7:0] ufir_byte_t;
    typedef logic [7:0] ufir_addr_t;
    typedef logic [31:0] ufir_word_t;
    typedef logic [2:0] ufir_bank1_t;
endpackage

// ==== hdl/ufir_regbus_if.sv ====
// internal register access strobes between bus slave and block core
`timescale 1ns/100ps
`default_nettype none
interface ufir_regbus_if;
    import ufir_pkg::*;
    logic wr_stb;
    logic rd_stb;
    ufir_addr_t addr;
    ufir_byte_t wdata;
    ufir_byte_t rdata;
    modport slave(output wr_stb, output rd_stb, output addr, output wdata, input rdata);
    modport core(input wr_stb, input rd_stb, input addr, input wdata, output rdata);
endinterface // ufir_regbus_if
`default_nettype wire

// ==== hdl/ufir_avmm_slave.sv ====
// avalon-mm slave with one wait state, drives the internal strobe interface
`timescale 1ns/100ps
`default_nettype none
module ufir_avmm_slave (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // avalon-mm
    input wire ufir_pkg::ufir_addr_t avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire ufir_pkg::ufir_word_t avs_writedata,
    output ufir_pkg::ufir_word_t avs_readdata,
    output logic avs_waitrequest,
    // core side
    ufir_regbus_if.slave rb
);
    import ufir_pkg::*;

    // ----------------------------------------
    // handshake
    // ----------------------------------------
    // waitrequest drops for exactly one cycle per request; the write lands on
    // the edge the master sees it low, the read capture one edge earlier while it is high
    logic req;
    assign req = avs_read | avs_write;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            avs_waitrequest <= 1'b1;
        end else if (req && avs_waitrequest) begin
            avs_waitrequest <= 1'b0;
        end else begin
            avs_waitrequest <= 1'b1;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            avs_readdata <= 32'h0000_0000;
        end else if (avs_read && avs_waitrequest) begin
            avs_readdata <= {24'h00_0000, rb.rdata};
        end
    end

    assign rb.addr = avs_address;
    assign rb.wdata = avs_writedata[7:0];
    assign rb.wr_stb = avs_write & ~avs_waitrequest;
    assign rb.rd_stb = avs_read & ~avs_waitrequest;
endmodule // ufir_avmm_slave
`default_nettype wire

// ==== hdl/ufir_top.sv ====
// usb function bank1 flags, line select registers and interrupt routing
//
// The implementer's own choices: register access over Avalon-MM and the register offsets.
`timescale 1ns/100ps
`default_nettype none
`include "ufir_defines.svh"
module ufir_top (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // avalon-mm register bus
    input wire ufir_pkg::ufir_addr_t avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire ufir_pkg::ufir_word_t avs_writedata,
    output ufir_pkg::ufir_word_t avs_readdata,
    output logic avs_waitrequest,
    // vbus pin, asynchronous
    input wire logic vbus_pin,
    // endpoint 3 engine, same clock
    input wire logic ep3_in_token,
    input wire logic ep3_fifo_valid,
    input wire logic ep3_ack_rx,
    output logic ep3_nack,
    // bank0 flag logic and enables, same clock
    input wire ufir_pkg::ufir_byte_t irq_flags_bank0,
    input wire ufir_pkg::ufir_byte_t irq_enable_bank0,
    input wire ufir_pkg::ufir_bank1_t irq_enable_bank1,
    output ufir_pkg::ufir_byte_t flags_bank0_clear,
    // toward the cpu interrupt controller
    output logic usb_irq_line_zero,
    output logic usb_irq_line_one,
    output logic irq_line_one_chosen,
    // block event interrupt
    output logic evt_irq
);
    import ufir_pkg::*;

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    // pending request of one bank on one line
    function automatic logic route_any(input ufir_byte_t flags, input ufir_byte_t en,
                                       input ufir_byte_t sel, input logic line);
        ufir_byte_t hit;
        hit = flags & en & (line ? sel : ~sel);
        return |hit;
    endfunction

    // write-zero-to-clear with set priority
    function automatic ufir_bank1_t w0c_set(input ufir_bank1_t cur, input ufir_bank1_t set,
                                            input logic wr, input ufir_bank1_t wval);
        ufir_bank1_t kept;
        kept = wr ? (cur & wval) : cur;
        return kept | set;
    endfunction

    // one register address compare, shared by the write strobes and the read mux
    function automatic logic addr_is(input ufir_addr_t a, input ufir_addr_t off);
        return a == off;
    endfunction

    // ----------------------------------------
    // register bus slave
    // ----------------------------------------
    ufir_regbus_if rb ();

    ufir_avmm_slave u_slave (
        .clk(clk),
        .resetn(resetn),
        .avs_address(avs_address),
        .avs_read(avs_read),
        .avs_write(avs_write),
        .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest),
        .rb(rb)
    );

    logic wr_flags1;
    logic wr_sel0;
    logic wr_sel1;
    logic wr_flags0;
    logic wr_evt_clr;
    logic wr_evt_en;
    assign wr_flags1 = rb.wr_stb && addr_is(rb.addr, `UFIR_OFF_FLAGS1);
    assign wr_sel0 = rb.wr_stb && addr_is(rb.addr, `UFIR_OFF_SEL0);
    assign wr_sel1 = rb.wr_stb && addr_is(rb.addr, `UFIR_OFF_SEL1);
    assign wr_flags0 = rb.wr_stb && addr_is(rb.addr, `UFIR_OFF_FLAGS0);
    assign wr_evt_clr = rb.wr_stb && addr_is(rb.addr, `UFIR_OFF_EVT_CLR);
    assign wr_evt_en = rb.wr_stb && addr_is(rb.addr, `UFIR_OFF_EVT_EN);

    // ----------------------------------------
    // vbus synchroniser
    // ----------------------------------------
    logic vbus_meta_reg;
    logic vbus_sync_reg;
    logic vbus_prev_reg;

    // the pin is asynchronous, so only the second flop feeds logic; the third
    // flop just remembers the last synced level for attach and detach edges
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            vbus_meta_reg <= 1'b0;
            vbus_sync_reg <= 1'b0;
            vbus_prev_reg <= 1'b0;
        end else begin
            vbus_meta_reg <= vbus_pin;
            vbus_sync_reg <= vbus_meta_reg;
            vbus_prev_reg <= vbus_sync_reg;
        end
    end

    logic vbus_rise;
    logic vbus_fall;
    assign vbus_rise = vbus_sync_reg & ~vbus_prev_reg;
    assign vbus_fall = ~vbus_sync_reg & vbus_prev_reg;

    // ----------------------------------------
    // endpoint 3 events
    // ----------------------------------------
    logic ep3_starved;
    assign ep3_starved = ep3_in_token & ~ep3_fifo_valid;

    // nack goes out one cycle after the token while no packet is armed
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ep3_nack <= 1'b0;
        end else begin
            ep3_nack <= ep3_starved;
        end
    end

    // ----------------------------------------
    // bank1 flags
    // ----------------------------------------
    ufir_bank1_t flags1_reg;
    ufir_bank1_t flags1_set;

    always_comb begin
        flags1_set = 3'h0;
        flags1_set[`UFIR_F1_EP3_REQ] = ep3_starved;
        flags1_set[`UFIR_F1_EP3_DONE] = ep3_ack_rx;
        flags1_set[`UFIR_F1_CONN] = vbus_rise | vbus_fall;
    end

    // a source firing in the clearing cycle keeps its flag set,
    // so software never loses an event that lands on its own clear
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            flags1_reg <= `UFIR_RST_FLAGS1;
        end else begin
            flags1_reg <= w0c_set(flags1_reg, flags1_set, wr_flags1, rb.wdata[2:0]);
        end
    end

    // ----------------------------------------
    // line select registers
    // ----------------------------------------
    ufir_byte_t sel0_reg;
    ufir_bank1_t sel1_reg;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sel0_reg <= `UFIR_RST_SEL0;
        end else if (wr_sel0) begin
            sel0_reg <= rb.wdata;
        end
    end

    // upper written bits are dropped, so reserved bits stay zero
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sel1_reg <= `UFIR_RST_SEL1;
        end else if (wr_sel1) begin
            sel1_reg <= rb.wdata[2:0];
        end
    end

    // ----------------------------------------
    // bank0 clear forwarding
    // ----------------------------------------
    // a zero bit written here becomes a one-cycle clear pulse for the
    // bank0 flag logic; the two fifo status bits are never cleared
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            flags_bank0_clear <= 8'h00;
        end else if (wr_flags0) begin
            flags_bank0_clear <= ~rb.wdata & ~`UFIR_F0_STATUS_MASK;
        end else begin
            flags_bank0_clear <= 8'h00;
        end
    end

    // ----------------------------------------
    // interrupt line routing
    // ----------------------------------------
    // bank1 is widened so one routing function serves both banks
    ufir_byte_t flags1_ext;
    ufir_byte_t en1_ext;
    ufir_byte_t sel1_ext;
    assign flags1_ext = {5'h00, flags1_reg};
    assign en1_ext = {5'h00, irq_enable_bank1};
    assign sel1_ext = {5'h00, sel1_reg};

    logic line0_next;
    logic line1_next;
    assign line0_next = route_any(irq_flags_bank0, irq_enable_bank0, sel0_reg, 1'b0)
                      | route_any(flags1_ext, en1_ext, sel1_ext, 1'b0);
    assign line1_next = route_any(irq_flags_bank0, irq_enable_bank0, sel0_reg, 1'b1)
                      | route_any(flags1_ext, en1_ext, sel1_ext, 1'b1);

    // one register stage keeps the outputs glitch free toward the controller
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            usb_irq_line_zero <= 1'b0;
            usb_irq_line_one <= 1'b0;
        end else begin
            usb_irq_line_zero <= line0_next;
            usb_irq_line_one <= line1_next;
        end
    end

    // tells the controller which vector to take; line zero wins a tie
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            irq_line_one_chosen <= 1'b0;
        end else begin
            irq_line_one_chosen <= line1_next & ~line0_next;
        end
    end

    // ----------------------------------------
    // block event status, clear and enable
    // ----------------------------------------
    // the block's own summary interrupt; a set beats a clear in the same cycle
    ufir_bank1_t evt_stat_reg;
    ufir_bank1_t evt_en_reg;
    ufir_bank1_t evt_set;
    ufir_bank1_t evt_clr;

    always_comb begin
        evt_set = 3'h0;
        evt_set[`UFIR_EVT_ATTACH] = vbus_rise;
        evt_set[`UFIR_EVT_DETACH] = vbus_fall;
        evt_set[`UFIR_EVT_NACK] = ep3_starved;
        evt_clr = wr_evt_clr ? rb.wdata[2:0] : 3'h0;
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            evt_stat_reg <= `UFIR_RST_EVT;
        end else begin
            evt_stat_reg <= (evt_stat_reg & ~evt_clr) | evt_set;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            evt_en_reg <= `UFIR_RST_EVT;
        end else if (wr_evt_en) begin
            evt_en_reg <= rb.wdata[2:0];
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            evt_irq <= 1'b0;
        end else begin
            evt_irq <= |(evt_stat_reg & evt_en_reg);
        end
    end

    // ----------------------------------------
    // read decode
    // ----------------------------------------
    // the clear register is write-only and reserved bits are tied low,
    // so reading back what was written shows zeros there
    ufir_byte_t rdata;
    ufir_byte_t flags1_view;

    always_comb begin
        flags1_view = 8'h00;
        flags1_view[`UFIR_F1_VBUS_MON] = vbus_sync_reg;
        flags1_view[`UFIR_F1_EP3_REQ] = flags1_reg[`UFIR_F1_EP3_REQ];
        flags1_view[`UFIR_F1_EP3_DONE] = flags1_reg[`UFIR_F1_EP3_DONE];
        flags1_view[`UFIR_F1_CONN] = flags1_reg[`UFIR_F1_CONN];
    end

    always_comb begin
        if (addr_is(rb.addr, `UFIR_OFF_FLAGS1)) begin
            rdata = flags1_view;
        end else if (addr_is(rb.addr, `UFIR_OFF_SEL0)) begin
            rdata = sel0_reg;
        end else if (addr_is(rb.addr, `UFIR_OFF_SEL1)) begin
            rdata = {5'h00, sel1_reg};
        end else if (addr_is(rb.addr, `UFIR_OFF_FLAGS0)) begin
            rdata = irq_flags_bank0;
        end else if (addr_is(rb.addr, `UFIR_OFF_EVT_STAT)) begin
            rdata = {5'h00, evt_stat_reg};
        end else if (addr_is(rb.addr, `UFIR_OFF_EVT_EN)) begin
            rdata = {5'h00, evt_en_reg};
        end else if (addr_is(rb.addr, `UFIR_OFF_EVT_CLR)) begin
            rdata = 8'h00;
        end else begin
            rdata = 8'h00;
        end
    end
    assign rb.rdata = rdata;
endmodule // ufir_top
`default_nettype wire

// ==== verification/ufir_cpu_irq_model.sv ====
// cpu interrupt controller model: takes one of the two usb request lines
`timescale 1ns/100ps
`default_nettype none
module ufir_cpu_irq_model (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // request lines
    input wire logic line_zero,
    input wire logic line_one,
    // serviced vector
    output logic pend_reg,
    output logic vec_one_reg
);
    // a tie goes to line zero, so line one is taken only when alone
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pend_reg <= 1'b0;
            vec_one_reg <= 1'b0;
        end else begin
            pend_reg <= line_zero | line_one;
            vec_one_reg <= line_one & ~line_zero;
        end
    end
endmodule // ufir_cpu_irq_model
`default_nettype wire

// ==== verification/ufir_top_assertions.sv ====
// port assertions of the usb flag routing block
`timescale 1ns/100ps
`default_nettype none
`include "ufir_defines.svh"
module ufir_top_assertions (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // register bus
    input wire ufir_pkg::ufir_addr_t avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire ufir_pkg::ufir_word_t avs_writedata,
    input wire ufir_pkg::ufir_word_t avs_readdata,
    input wire logic avs_waitrequest,
    // usb side
    input wire logic vbus_pin,
    input wire logic ep3_in_token,
    input wire logic ep3_fifo_valid,
    input wire logic ep3_nack,
    // routing
    input wire ufir_pkg::ufir_byte_t irq_enable_bank0,
    input wire ufir_pkg::ufir_bank1_t irq_enable_bank1,
    input wire ufir_pkg::ufir_byte_t flags_bank0_clear,
    input wire logic usb_irq_line_zero,
    input wire logic usb_irq_line_one,
    input wire logic irq_line_one_chosen
);
    import ufir_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    ufir_byte_t wd_q;
    logic rd_ok;
    logic wr_ok;
    assign rd_ok = avs_read && !avs_waitrequest;
    assign wr_ok = avs_write && !avs_waitrequest;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) wd_q <= 8'h00;
        else wd_q <= avs_writedata[7:0];
    end
    property p_nack;
        ep3_in_token && !ep3_fifo_valid |=> ep3_nack;
    endproperty
    property p_nack_cause;
        ep3_nack |-> $past(ep3_in_token) && !$past(ep3_fifo_valid);
    endproperty
    property p_rsv_flags;
        rd_ok && avs_address == `UFIR_OFF_FLAGS1 |-> avs_readdata[7:4] == 4'h0;
    endproperty
    property p_rsv_sel;
        rd_ok && avs_address == `UFIR_OFF_SEL1 |-> avs_readdata[7:3] == 5'h00;
    endproperty
    property p_vbus;
        $stable(vbus_pin) [*5] ##0 (rd_ok && avs_address == `UFIR_OFF_FLAGS1)
            |-> avs_readdata[3] == vbus_pin;
    endproperty
    property p_no_en;
        (irq_enable_bank0 == 8'h00 && irq_enable_bank1 == 3'h0) [*2]
            |-> !usb_irq_line_zero && !usb_irq_line_one;
    endproperty
    property p_prio;
        irq_line_one_chosen == (usb_irq_line_one && !usb_irq_line_zero);
    endproperty
    property p_status_keep;
        (flags_bank0_clear & `UFIR_F0_STATUS_MASK) == 8'h00;
    endproperty
    property p_clr_pulse;
        wr_ok && avs_address == `UFIR_OFF_FLAGS0
            |=> flags_bank0_clear == (~wd_q & ~`UFIR_F0_STATUS_MASK);
    endproperty
    a_nack: assert property (p_nack) else $error("nack missing");
    a_nack_cause: assert property (p_nack_cause) else $error("nack uncaused");
    a_rsv_flags: assert property (p_rsv_flags) else $error("flag reserved bits");
    a_rsv_sel: assert property (p_rsv_sel) else $error("select reserved bits");
    a_vbus: assert property (p_vbus) else $error("vbus monitor bit wrong");
    a_no_en: assert property (p_no_en) else $error("line without enable");
    a_prio: assert property (p_prio) else $error("line zero not preferred");
    a_status_keep: assert property (p_status_keep) else $error("status bit cleared");
    a_clr_pulse: assert property (p_clr_pulse) else $error("bank0 clear wrong");
    c_nack: cover property (ep3_nack);
    c_clr: cover property (flags_bank0_clear != 8'h00);
    c_both: cover property (usb_irq_line_zero && usb_irq_line_one);
endmodule // ufir_top_assertions
bind ufir_top ufir_top_assertions u_ufir_top_assertions (.clk, .resetn, .avs_address,
    .avs_read, .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .vbus_pin,
    .ep3_in_token, .ep3_fifo_valid, .ep3_nack, .irq_enable_bank0, .irq_enable_bank1,
    .flags_bank0_clear, .usb_irq_line_zero, .usb_irq_line_one, .irq_line_one_chosen);
`default_nettype wire

// ==== verification/test_ufir_top.sv ====
// self-checking bench of the usb flag routing block
`timescale 1ns/100ps
`default_nettype none
`include "ufir_defines.svh"
module test_ufir_top;
    import ufir_pkg::*;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    ufir_addr_t adr = 8'h00;
    logic rd_q = 1'b0, wr_q = 1'b0, vbus = 1'b0, tok = 1'b0, fvalid = 1'b0, ack = 1'b0;
    ufir_word_t wdat = 32'h00000000;
    ufir_word_t rdat;
    logic wait_q, nack, line0, line1, chosen, evt_irq, pend, vec_one;
    ufir_byte_t flags0 = 8'h00, en0 = 8'h00, clr0, rd;
    ufir_bank1_t en1 = 3'h0;
    int fail_count = 0;
    int checks_done = 0;
    always #20 clk = ~clk;
    ufir_top u_ufir_top (.clk(clk), .resetn(resetn), .avs_address(adr), .avs_read(rd_q),
        .avs_write(wr_q), .avs_writedata(wdat), .avs_readdata(rdat), .avs_waitrequest(wait_q),
        .vbus_pin(vbus), .ep3_in_token(tok), .ep3_fifo_valid(fvalid), .ep3_ack_rx(ack),
        .ep3_nack(nack), .irq_flags_bank0(flags0), .irq_enable_bank0(en0),
        .irq_enable_bank1(en1), .flags_bank0_clear(clr0), .usb_irq_line_zero(line0),
        .usb_irq_line_one(line1), .irq_line_one_chosen(chosen), .evt_irq(evt_irq));
    ufir_cpu_irq_model u_ufir_cpu_irq_model (.clk(clk), .resetn(resetn), .line_zero(line0),
        .line_one(line1), .pend_reg(pend), .vec_one_reg(vec_one));
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // request held until waitrequest is sampled low, then released
    task automatic bus(input logic wr, input ufir_addr_t a, input ufir_byte_t d);
        int n = 0;
        adr <= a;
        wr_q <= wr;
        rd_q <= !wr;
        wdat <= {24'h000000, d};
        do begin
            @(posedge clk);
            n++;
        end while (wait_q !== 1'b0 && n < 50);
        if (n >= 50) begin
            fail_count++;
            $display("Error %0t: bus answer timed out", $time);
        end
        rd = rdat[7:0];
        rd_q <= 1'b0;
        wr_q <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rdchk(input ufir_addr_t a, input ufir_byte_t e);
        bus(1'b0, a, 8'h00);
        check(rd, e);
    endtask
    task automatic ticks(input int k);
        repeat (k) @(posedge clk);
    endtask
    task automatic t_regs();
        rdchk(`UFIR_OFF_SEL0, `UFIR_RST_SEL0);
        rdchk(`UFIR_OFF_SEL1, 8'h07);
        rdchk(`UFIR_OFF_FLAGS1, 8'h00);
        bus(1'b1, `UFIR_OFF_SEL0, 8'hA5);
        rdchk(`UFIR_OFF_SEL0, 8'hA5);
        bus(1'b1, `UFIR_OFF_SEL1, 8'hFA);
        rdchk(`UFIR_OFF_SEL1, 8'h02);
        bus(1'b1, 8'h3C, 8'hFF);
        rdchk(8'h3C, 8'h00);
        bus(1'b1, `UFIR_OFF_SEL0, 8'h00);
        bus(1'b1, `UFIR_OFF_SEL1, 8'h07);
    endtask
    task automatic t_ep3();
        tok <= 1'b1;
        @(posedge clk);
        tok <= 1'b0;
        @(posedge clk);
        check({7'h00, nack}, 8'h01);
        fvalid <= 1'b1;
        tok <= 1'b1;
        @(posedge clk);
        tok <= 1'b0;
        ack <= 1'b1;
        @(posedge clk);
        ack <= 1'b0;
        fvalid <= 1'b0;
        check({7'h00, nack}, 8'h00);
        rdchk(`UFIR_OFF_FLAGS1, 8'h06);
        bus(1'b1, `UFIR_OFF_FLAGS1, 8'hFB);
        rdchk(`UFIR_OFF_FLAGS1, 8'h02);
        bus(1'b1, `UFIR_OFF_FLAGS1, 8'hFD);
        rdchk(`UFIR_OFF_FLAGS1, 8'h00);
    endtask
    task automatic t_vbus();
        vbus <= 1'b1;
        ticks(6);
        rdchk(`UFIR_OFF_FLAGS1, 8'h09);
        bus(1'b1, `UFIR_OFF_FLAGS1, 8'hF0);
        rdchk(`UFIR_OFF_FLAGS1, 8'h08);
        rdchk(`UFIR_OFF_EVT_STAT, 8'h05);
        bus(1'b1, `UFIR_OFF_EVT_EN, 8'h01);
        ticks(2);
        check({7'h00, evt_irq}, 8'h01);
        bus(1'b1, `UFIR_OFF_EVT_CLR, 8'h01);
        ticks(2);
        check({7'h00, evt_irq}, 8'h00);
        vbus <= 1'b0;
        ticks(6);
        rdchk(`UFIR_OFF_FLAGS1, 8'h01);
        rdchk(`UFIR_OFF_EVT_STAT, 8'h06);
        bus(1'b1, `UFIR_OFF_EVT_EN, 8'h00);
        ticks(2);
        check({7'h00, evt_irq}, 8'h00);
        bus(1'b1, `UFIR_OFF_EVT_CLR, 8'h07);
        rdchk(`UFIR_OFF_EVT_STAT, 8'h00);
    endtask
    task automatic t_route();
        en1 <= 3'h1;
        ticks(3);
        check({4'h0, line0, line1, chosen, vec_one}, 8'h07);
        bus(1'b1, `UFIR_OFF_SEL1, 8'h06);
        ticks(3);
        check({4'h0, line0, line1, chosen, pend}, 8'h09);
        flags0 <= 8'h80;
        en0 <= 8'h80;
        bus(1'b1, `UFIR_OFF_SEL0, 8'h80);
        ticks(3);
        check({4'h0, line0, line1, chosen, vec_one}, 8'h0C);
        en1 <= 3'h0;
        ticks(3);
        check({4'h0, line0, line1, chosen, vec_one}, 8'h07);
        en0 <= 8'h00;
        ticks(3);
        check({5'h00, line0, line1, pend}, 8'h00);
        bus(1'b1, `UFIR_OFF_FLAGS0, 8'h00);
        check(clr0, 8'hAF);
        bus(1'b1, `UFIR_OFF_FLAGS0, 8'h7F);
        check(clr0, 8'h80);
    endtask
    // reset in mid-run must bring the selects and flags back to their start values
    task automatic t_reset();
        bus(1'b1, `UFIR_OFF_SEL0, 8'h3C);
        bus(1'b1, `UFIR_OFF_SEL1, 8'h00);
        rdchk(`UFIR_OFF_SEL1, 8'h00);
        resetn <= 1'b0;
        ticks(3);
        resetn <= 1'b1;
        @(posedge clk);
        rdchk(`UFIR_OFF_SEL0, 8'h00);
        rdchk(`UFIR_OFF_SEL1, 8'h07);
        rdchk(`UFIR_OFF_FLAGS1, 8'h00);
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        t_regs();
        t_ep3();
        t_vbus();
        t_route();
        t_reset();
        final_report();
    end
    initial begin
        #400000;
        fail_count++;
        final_report();
    end
endmodule // test_ufir_top
`default_nettype wire
